// [dv/pgm_pin_world.sv]
// far-side circuitry on the gpio pins: drives released pins
// assumes pin_oe_i high while the block drives a pin
`timescale 1ns/1ps
module pgm_pin_world (
	input wire logic clock_i,
	input wire logic [7:0] pin_drive_i,
	input wire logic [7:0] pin_oe_i,
	input wire logic [7:0] ext_oe_i,
	input wire logic [7:0] ext_val_i,
	output logic [7:0] pin_level_o
);
	logic [7:0] pat_r;
	// floating pins change every cycle so a stale value never passes
	always_ff @(posedge clock_i) begin
		pat_r <= (pat_r === 8'h55) ? 8'haa : 8'h55;
	end
	assign pin_level_o = (pin_oe_i & pin_drive_i) | (~pin_oe_i & ext_oe_i & ext_val_i)
		| (~pin_oe_i & ~ext_oe_i & pat_r);
endmodule : pgm_pin_world

// [dv/pgm_top_asserts.sv]
// checker of pin, debug-out and bus relations of pgm_top
// assumes bind onto pgm_top; one clock, sync reset
`timescale 1ns/1ps
module pgm_top_asserts
	import pgm_pkg::*;
#(
	parameter int PINS = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	input wire logic [PINS-1:0] pin_drive_o,
	input wire logic [PINS-1:0] pin_oe_o,
	input wire logic clock_source_i,
	input wire logic [3:0] scan_default_oe_i,
	input wire logic scan_strap_i,
	input wire logic fast_pad_switching_o,
	input wire logic debug_signal_out_pin_o,
	input wire logic debug_signal_out_oe_o
);
	logic [7:0] wd_r;
	logic acc, w_oe, w_out, w_sel;
	assign acc = avs_write_i && !avs_waitrequest_o;
	assign w_oe = acc && avs_address_i[9:2] == PGM_IDX_PIN_OE;
	assign w_out = acc && avs_address_i[9:2] == PGM_IDX_PIN_OUT;
	assign w_sel = acc && avs_address_i[9:2] == PGM_IDX_SIG_SEL;
	// keep the accepted byte; outputs lag the write by up to two edges
	always_ff @(posedge clock_i) begin
		if (acc) begin
			wd_r <= avs_writedata_i[7:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	AST_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("waitrequest longer than one cycle");
	AST_OE_HI: assert property (w_oe |-> ##2 {pin_oe_o[7], pin_oe_o[5:4]}
		== {wd_r[7], wd_r[5:4]}) else $error("pin enable not applied");
	AST_OE_SCAN: assert property (w_oe && !scan_strap_i |-> ##2 pin_oe_o[3:0]
		== (wd_r[3:0] | scan_default_oe_i)) else $error("scan pin enable wrong");
	AST_STRAP: assert property (scan_strap_i && $past(scan_strap_i, 5)
		|-> pin_oe_o[3:0] == scan_default_oe_i) else $error("strap ignored");
	AST_DRIVE: assert property (w_out |-> ##2 (pin_drive_o & pin_oe_o & 8'hb0)
		== (wd_r & pin_oe_o & 8'hb0)) else $error("pin drive value wrong");
	AST_CLOCK: assert property (w_oe && !avs_writedata_i[6] |-> ##3 pin_oe_o[6]
		&& pin_drive_o[6] == $past(clock_source_i)) else $error("clock pin not driven");
	AST_SEL_OE: assert property (w_sel |-> ##2 debug_signal_out_oe_o
		== (wd_r[3:0] inside {[4'h2:4'h9]})) else $error("signal-out enable wrong");
	AST_SEL_LVL: assert property (w_sel && avs_writedata_i[3:1] == 3'b001
		|-> ##2 debug_signal_out_pin_o == wd_r[0]) else $error("signal-out level wrong");
	AST_FAST: assert property (w_sel |-> ##2 fast_pad_switching_o == wd_r[7])
		else $error("pad speed wrong");
endmodule : pgm_top_asserts
////////////////////////////////////////////////////////////////
bind pgm_top pgm_top_asserts #(.PINS(PINS)) i_asserts (.clock_i, .rst_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .pin_drive_o, .pin_oe_o,
	.clock_source_i, .scan_default_oe_i, .scan_strap_i, .fast_pad_switching_o,
	.debug_signal_out_pin_o, .debug_signal_out_oe_o);

// [dv/pgm_top_tb.sv]
// bench of pgm_top: bus tasks, pin model and signal-out sources
// assumes pgm_pkg, pgm_top, pgm_pin_world and the checker compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end
module pgm_top_tb
	import pgm_pkg::*;
;
	logic clock_i, rst_i, avs_read_i, avs_write_i, clock_source_i, scan_strap_i, irq_o;
	logic avs_waitrequest_o, fast_pad_switching_o, debug_signal_out_pin_o, debug_signal_out_oe_o;
	logic detect_start_i, detect_done_i;
	logic [9:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [1:0] avs_response_o, rsp;
	logic [7:0] pin_level_i, pin_drive_o, pin_oe_o, ext_oe, ext_val;
	logic [5:0] src, i_value_i, q_value_i;
	logic [3:0] dflt_oe;
	int n_mismatch, cmp_count, k;
	pgm_top #(.PINS(8)) i_dut (.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
		.avs_response_o, .pin_level_i, .pin_drive_o, .pin_oe_o, .clock_source_i,
		.scan_default_oe_i(dflt_oe), .scan_default_out_i(4'h9), .scan_strap_i,
		.fast_pad_switching_o, .debug_signal_out_pin_o, .debug_signal_out_oe_o,
		.tx_envelope_i(src[0]), .tx_active_i(src[1]), .generic_secure_channel_signal_i(src[2]),
		.rx_envelope_i(src[3]), .rx_active_i(src[4]), .rx_bit_i(src[5]), .detect_start_i,
		.detect_done_i, .i_value_i, .q_value_i, .irq_o);
	pgm_pin_world i_world (.clock_i, .pin_drive_i(pin_drive_o), .pin_oe_i(pin_oe_o),
		.ext_oe_i(ext_oe), .ext_val_i(ext_val), .pin_level_o(pin_level_i));
	////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) clock_source_i <= ~clock_source_i;
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_address_i <= {idx, 2'b00};
		avs_writedata_i <= d;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		rd = avs_readdata_o;
		rsp = avs_response_o;
		avs_read_i <= 0;
		avs_write_i <= 0;
		if (n >= 50) n_mismatch++;
	endtask : bus
	task automatic rc(input logic [7:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 32'h0);
		`CHK(rd, e)
	endtask : rc
	task automatic run(input logic st, input logic [5:0] i, q);
		@(posedge clock_i);
		detect_start_i <= st;
		i_value_i <= i;
		q_value_i <= q;
		@(posedge clock_i);
		detect_start_i <= 0;
		detect_done_i <= 1;
		@(posedge clock_i);
		detect_done_i <= 0;
		cyc(2);
	endtask : run
	task automatic give_verdict;
		if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	// generous bound: the sequence needs a few hundred cycles
	initial begin
		#100000;
		n_mismatch++;
		give_verdict;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_i, avs_read_i, avs_write_i, scan_strap_i, detect_start_i, detect_done_i} = 6'h20;
		{clock_source_i, avs_address_i, avs_writedata_i, src, i_value_i, q_value_i} = '0;
		{ext_oe, ext_val, n_mismatch, cmp_count} = '0;
		dflt_oe = 4'h5;
		cyc(16);
		rst_i <= 0;
		rc(PGM_IDX_PIN_OE, PGM_RST_PIN_OE);
		rc(PGM_IDX_SIG_SEL, PGM_RST_SIG_SEL);
		rc(8'h50, 32'h0);
		`CHK(rsp, 2'b11)
		bus(1, PGM_IDX_PIN_OE, 32'hff);
		bus(1, PGM_IDX_PIN_OUT, 32'ha5);
		cyc(4);
		`CHK(pin_oe_o, 8'hff)
		`CHK(pin_drive_o, 8'ha5)
		rc(PGM_IDX_PIN_IN, 32'ha5);
		bus(1, PGM_IDX_PIN_IN, 32'h00);
		rc(PGM_IDX_PIN_IN, 32'ha5);
		ext_oe <= 8'hff;
		ext_val <= 8'h3c;
		bus(1, PGM_IDX_PIN_OE, 32'h00);
		cyc(4);
		`CHK(pin_oe_o, 8'h45)
		`CHK(pin_drive_o[3:0], 4'h9)
		bus(0, PGM_IDX_PIN_IN, 32'h0);
		`CHK(rd[7:0] & 8'hbf, 8'h39)
		scan_strap_i <= 1;
		dflt_oe <= 4'ha;
		bus(1, PGM_IDX_PIN_OE, 32'h0f);
		cyc(6);
		`CHK(pin_oe_o[3:0], 4'ha)
		scan_strap_i <= 0;
		cyc(6);
		`CHK(pin_oe_o[3:0], 4'hf)
		for (k = 0; k < 16; k++) begin
			bus(1, PGM_IDX_SIG_SEL, {k[0], 3'b111, k[3:0]});
			src <= (k > 3 && k < 10) ? 6'h1 << (k - 4) : 6'h0;
			cyc(3);
			`CHK(debug_signal_out_oe_o, k inside {[2:9]})
			if (k > 1 && k < 10) `CHK(debug_signal_out_pin_o, k != 2)
			src <= ~src;
			cyc(3);
			if (k > 3 && k < 10) `CHK(debug_signal_out_pin_o, 1'b0)
			`CHK(fast_pad_switching_o, k[0])
			rc(PGM_IDX_SIG_SEL, {k[0], 3'b000, k[3:0]});
		end
		bus(1, PGM_IDX_CD_BORDERS, 32'h50a50a);
		bus(1, PGM_IDX_IRQ_ENABLE, 32'h01);
		run(1, 6'd15, 6'd15);
		rc(PGM_IDX_IRQ_STATUS, 32'h02);
		`CHK(irq_o, 1'b0)
		run(1, 6'd15, 6'd5);
		rc(PGM_IDX_IRQ_STATUS, 32'h03);
		`CHK(irq_o, 1'b1)
		bus(1, PGM_IDX_IRQ_ENABLE, 32'h00);
		cyc(2);
		`CHK(irq_o, 1'b0)
		bus(1, PGM_IDX_IRQ_ENABLE, 32'h01);
		bus(1, PGM_IDX_CD_Q_RESULT, 32'h7f);
		rc(PGM_IDX_CD_Q_RESULT, 32'h45);
		bus(1, PGM_IDX_IRQ_CLEAR, 32'h03);
		rc(PGM_IDX_IRQ_CLEAR, 32'h00);
		run(0, 6'd30, 6'd15);
		rc(PGM_IDX_IRQ_STATUS, 32'h02);
		`CHK(irq_o, 1'b0)
		run(1, 6'd30, 6'd15);
		rc(PGM_IDX_CD_Q_RESULT, 32'h0f);
		`CHK(irq_o, 1'b1)
		rst_i <= 1;
		cyc(2);
		rst_i <= 0;
		rc(PGM_IDX_PIN_OE, PGM_RST_PIN_OE);
		`CHK(pin_oe_o, 8'h4a)
		`CHK(fast_pad_switching_o, 1'b0)
		`CHK(irq_o, 1'b0)
		give_verdict;
	end
endmodule : pgm_top_tb

// [hdl/pgm_pkg.sv]
// constants of the pin gpio and signal-out mux block
// assumes an 8-bit register file reached over a 32-bit avalon-mm slave
package pgm_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] PGM_IDX_CD_Q_RESULT = 8'h43;
	localparam logic [7:0] PGM_IDX_PIN_OE = 8'h44;
	localparam logic [7:0] PGM_IDX_PIN_OUT = 8'h45;
	localparam logic [7:0] PGM_IDX_PIN_IN = 8'h46;
	localparam logic [7:0] PGM_IDX_SIG_SEL = 8'h47;
	localparam logic [7:0] PGM_IDX_IRQ_STATUS = 8'h48;
	localparam logic [7:0] PGM_IDX_IRQ_ENABLE = 8'h49;
	localparam logic [7:0] PGM_IDX_IRQ_CLEAR = 8'h4a;
	localparam logic [7:0] PGM_IDX_CD_BORDERS = 8'h4b;
	// field positions
	localparam int PGM_BIT_CD_IRQ_CLEAR = 6;
	localparam int PGM_BIT_FAST_PAD = 7;
	localparam int PGM_FIRST_SCAN_BIT = 0;
	localparam int PGM_LAST_SCAN_BIT = 3;
	localparam int PGM_BIT_CLOCK_PIN = 6;
	// status bits
	localparam int PGM_ST_CARD_DETECT = 0;
	localparam int PGM_ST_DETECT_DONE = 1;
	localparam int PGM_ST_WIDTH = 2;
	// reset values
	localparam logic [7:0] PGM_RST_PIN_OE = 8'h00;
	localparam logic [7:0] PGM_RST_PIN_OUT = 8'h00;
	localparam logic [7:0] PGM_RST_SIG_SEL = 8'h00;
	localparam logic [5:0] PGM_RST_Q_VALUE = 6'h00;
	localparam logic [23:0] PGM_RST_BORDERS = 24'h3f_003f;
	// debug signal-out selector codes
	localparam logic [3:0] PGM_SEL_TRI0 = 4'h0;
	localparam logic [3:0] PGM_SEL_TRI1 = 4'h1;
	localparam logic [3:0] PGM_SEL_LOW = 4'h2;
	localparam logic [3:0] PGM_SEL_HIGH = 4'h3;
	localparam logic [3:0] PGM_SEL_TX_ENV = 4'h4;
	localparam logic [3:0] PGM_SEL_TX_ACT = 4'h5;
	localparam logic [3:0] PGM_SEL_SECURE = 4'h6;
	localparam logic [3:0] PGM_SEL_RX_ENV = 4'h7;
	localparam logic [3:0] PGM_SEL_RX_ACT = 4'h8;
	localparam logic [3:0] PGM_SEL_RX_BIT = 4'h9;
endpackage : pgm_pkg

// [hdl/pgm_sync2.sv]
// two flip-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to clock_i
`timescale 1ns/1ps
module pgm_sync2 #(
	parameter int WIDTH = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule : pgm_sync2

// [hdl/pgm_top.sv]
// pin gpio, debug signal-out mux and card-detect q result register
// assumes avalon-mm master on clock_i; measurement inputs are same-domain
// Contract
// - irq clear bit blocks irq until next run
// - q bits 5..0 read-only last measurement
// - bit7 enables aux input pin driver
// - bit6 makes clock pin gpio, stops clock
// - bits5,4 enable host select pin drivers
// - bits3..0 enable scan pin drivers
// - scan enables ignored when scan strapped on
// - output register supplies each gpio-enabled pin value
// - input register reads present pin levels
// - bit7 selects fast pad switching
// - codes 0,1 tristate, 2 low, 3 high
// - codes 4,5,6 route transmit side signals
// - codes 7,8,9 route receive side signals
// - irq when i or q leaves borders
`timescale 1ns/1ps
module pgm_top
	import pgm_pkg::*;
#(
	parameter int PINS = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	// pins: 7 aux in, 6 clock out, 5/4 host select, 3..0 tck tms tdi tdo
	input wire logic [PINS-1:0] pin_level_i,
	output logic [PINS-1:0] pin_drive_o,
	output logic [PINS-1:0] pin_oe_o,
	// default functions of the pins
	input wire logic clock_source_i,
	input wire logic [3:0] scan_default_oe_i,
	input wire logic [3:0] scan_default_out_i,
	input wire logic scan_strap_i,
	output logic fast_pad_switching_o,
	// debug signal-out pin
	output logic debug_signal_out_pin_o,
	output logic debug_signal_out_oe_o,
	input wire logic tx_envelope_i,
	input wire logic tx_active_i,
	input wire logic generic_secure_channel_signal_i,
	input wire logic rx_envelope_i,
	input wire logic rx_active_i,
	input wire logic rx_bit_i,
	// low-power card detect measurement
	input wire logic detect_start_i,
	input wire logic detect_done_i,
	input wire logic [5:0] i_value_i,
	input wire logic [5:0] q_value_i,
	output logic irq_o
);
	if (PINS != 8) begin : g_bad_pins
		$error("pgm_top serves exactly eight pins");
	end
	if (PGM_LAST_SCAN_BIT - PGM_FIRST_SCAN_BIT != 3) begin : g_bad_scan
		$error("pgm_top expects four scan pins");
	end
	if (PGM_ST_WIDTH > 8) begin : g_bad_status
		$error("status bits must fit one byte lane");
	end

	////////////////////////////////////////////////////////////////////////
	logic [PINS-1:0] pin_oe_r;
	logic [PINS-1:0] pin_out_r;
	logic [7:0] sig_sel_r;
	logic [5:0] q_value_r;
	logic cd_irq_clear_r;
	logic [PGM_ST_WIDTH-1:0] irq_status_r;
	logic [PGM_ST_WIDTH-1:0] irq_enable_r;
	logic [23:0] borders_r;
	logic [PINS-1:0] pin_sync;
	logic strap_sync;
	logic scan_on_r;
	logic ack_r;
	logic [31:0] rdata_nxt;
	logic hit;
	logic [7:0] idx;
	logic wr_go;
	logic rd_go;
	logic cd_event;

	assign idx = avs_address_i[9:2];
	assign wr_go = avs_write_i && !ack_r;
	assign rd_go = avs_read_i && !ack_r;
	// one wait state: ack pulses the cycle after the request is seen
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_i || avs_write_i) && !ack_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin levels come from pads, so they are synchronised first
	pgm_sync2 #(
		.WIDTH(PINS)
	) u_pin_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i(pin_level_i),
		.sync_o(pin_sync)
	);

	// the strap is a pad level as well and passes the same synchroniser
	pgm_sync2 #(
		.WIDTH(1)
	) u_strap_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i(scan_strap_i),
		.sync_o(strap_sync)
	);

	// strap taken after release, never through the reset branch
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scan_on_r <= 1'b0;
		end else begin
			scan_on_r <= strap_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writable registers; writes land on the waitrequest-low edge
	logic wr_acc;
	logic wr_lane0;
	logic wr_pin_oe;
	logic wr_pin_out;
	logic wr_sig_sel;
	logic wr_irq_en;
	logic wr_borders;
	logic wr_q_result;
	logic wr_irq_clr;
	assign wr_acc = avs_write_i && ack_r;
	assign wr_lane0 = wr_acc && avs_byteenable_i[0];
	assign wr_pin_oe = wr_lane0 && (idx == PGM_IDX_PIN_OE);
	assign wr_pin_out = wr_lane0 && (idx == PGM_IDX_PIN_OUT);
	assign wr_sig_sel = wr_lane0 && (idx == PGM_IDX_SIG_SEL);
	assign wr_irq_en = wr_lane0 && (idx == PGM_IDX_IRQ_ENABLE);
	assign wr_borders = wr_acc && (idx == PGM_IDX_CD_BORDERS);
	assign wr_q_result = wr_lane0 && (idx == PGM_IDX_CD_Q_RESULT);
	assign wr_irq_clr = wr_lane0 && (idx == PGM_IDX_IRQ_CLEAR);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pin_oe_r <= PGM_RST_PIN_OE;
		end else if (wr_pin_oe) begin
			pin_oe_r <= avs_writedata_i[7:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pin_out_r <= PGM_RST_PIN_OUT;
		end else if (wr_pin_out) begin
			pin_out_r <= avs_writedata_i[7:0];
		end
	end

	// reserved bits 6..4 are never stored, so they read back zero
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sig_sel_r <= PGM_RST_SIG_SEL;
		end else if (wr_sig_sel) begin
			sig_sel_r <= {avs_writedata_i[7], 3'h0, avs_writedata_i[3:0]};
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_enable_r <= '0;
		end else if (wr_irq_en) begin
			irq_enable_r <= avs_writedata_i[PGM_ST_WIDTH-1:0];
		end
	end

	// borders are the only register wider than one byte lane
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			borders_r <= PGM_RST_BORDERS;
		end else if (wr_borders) begin
			for (int lane = 0; lane < 3; lane++) begin
				if (avs_byteenable_i[lane]) begin
					borders_r[8*lane +: 8] <= avs_writedata_i[8*lane +: 8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// card detect: borders are {i_max,i_min,q_max,q_min}, six bits each
	logic out_of_border;
	assign out_of_border = (i_value_i < borders_r[17:12]) || (i_value_i > borders_r[23:18])
		|| (q_value_i < borders_r[5:0]) || (q_value_i > borders_r[11:6]);
	assign cd_event = detect_done_i && out_of_border && !cd_irq_clear_r;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q_value_r <= PGM_RST_Q_VALUE;
		end else if (detect_done_i) begin
			q_value_r <= q_value_i;
		end
	end

	// a new run re-arms; a software set in the same cycle as a start wins
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cd_irq_clear_r <= 1'b0;
		end else if (wr_q_result && avs_writedata_i[PGM_BIT_CD_IRQ_CLEAR]) begin
			cd_irq_clear_r <= 1'b1;
		end else if (detect_start_i) begin
			cd_irq_clear_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status; a set in the clearing cycle wins
	logic [PGM_ST_WIDTH-1:0] st_set;
	logic [PGM_ST_WIDTH-1:0] st_clr;
	assign st_set = {detect_done_i, cd_event};
	assign st_clr = wr_irq_clr ? avs_writedata_i[PGM_ST_WIDTH-1:0] : '0;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_status_r <= '0;
		end else begin
			irq_status_r <= (irq_status_r & ~st_clr) | st_set;
		end
	end

	// level output; only the clear register takes a status bit down
	assign irq_o = |(irq_status_r & irq_enable_r);

	////////////////////////////////////////////////////////////////////////
	// pin drivers
	logic [PINS-1:0] gpio_en;
	always_comb begin
		gpio_en = pin_oe_r;
		if (scan_on_r) begin
			gpio_en[PGM_LAST_SCAN_BIT:PGM_FIRST_SCAN_BIT] = 4'h0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pin_oe_o <= '0;
			pin_drive_o <= '0;
		end else begin
			for (int b = 0; b < PINS; b++) begin
				pin_oe_o[b] <= gpio_en[b];
				pin_drive_o[b] <= pin_out_r[b];
			end
			// disabled clock and scan pins fall back to their own function
			if (!gpio_en[PGM_BIT_CLOCK_PIN]) begin
				pin_oe_o[PGM_BIT_CLOCK_PIN] <= 1'b1;
				pin_drive_o[PGM_BIT_CLOCK_PIN] <= clock_source_i;
			end
			for (int s = 0; s < 4; s++) begin
				if (!gpio_en[s]) begin
					pin_oe_o[s] <= scan_default_oe_i[s];
					pin_drive_o[s] <= scan_default_out_i[s];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// debug signal-out pin
	logic dbg_val;
	logic dbg_oe;
	always_comb begin
		dbg_val = 1'b0;
		dbg_oe = 1'b1;
		case (sig_sel_r[3:0])
			PGM_SEL_TRI0, PGM_SEL_TRI1: dbg_oe = 1'b0;
			PGM_SEL_LOW: dbg_val = 1'b0;
			PGM_SEL_HIGH: dbg_val = 1'b1;
			PGM_SEL_TX_ENV: dbg_val = tx_envelope_i;
			PGM_SEL_TX_ACT: dbg_val = tx_active_i;
			PGM_SEL_SECURE: dbg_val = generic_secure_channel_signal_i;
			PGM_SEL_RX_ENV: dbg_val = rx_envelope_i;
			PGM_SEL_RX_ACT: dbg_val = rx_active_i;
			PGM_SEL_RX_BIT: dbg_val = rx_bit_i;
			default: dbg_oe = 1'b0;
		endcase
	end

	// fast pads raise peak supply current, so they stay off after reset
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			debug_signal_out_pin_o <= 1'b0;
			debug_signal_out_oe_o <= 1'b0;
			fast_pad_switching_o <= 1'b0;
		end else begin
			debug_signal_out_pin_o <= dbg_val;
			debug_signal_out_oe_o <= dbg_oe;
			fast_pad_switching_o <= sig_sel_r[PGM_BIT_FAST_PAD];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unmapped reads return zero with a decode-error response
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		hit = 1'b1;
		case (idx)
			PGM_IDX_CD_Q_RESULT: rdata_nxt[7:0] = {1'b0, cd_irq_clear_r, q_value_r};
			PGM_IDX_PIN_OE: rdata_nxt[7:0] = pin_oe_r;
			PGM_IDX_PIN_OUT: rdata_nxt[7:0] = pin_out_r;
			PGM_IDX_PIN_IN: rdata_nxt[7:0] = pin_sync;
			PGM_IDX_SIG_SEL: rdata_nxt[7:0] = sig_sel_r;
			PGM_IDX_IRQ_STATUS: rdata_nxt[PGM_ST_WIDTH-1:0] = irq_status_r;
			PGM_IDX_IRQ_ENABLE: rdata_nxt[PGM_ST_WIDTH-1:0] = irq_enable_r;
			PGM_IDX_IRQ_CLEAR: rdata_nxt = 32'h0000_0000;
			PGM_IDX_CD_BORDERS: rdata_nxt[23:0] = borders_r;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
			avs_response_o <= 2'h0;
		end else if (rd_go || wr_go) begin
			avs_readdata_o <= rd_go ? rdata_nxt : 32'h0000_0000;
			avs_response_o <= hit ? 2'h0 : 2'h3;
		end
	end
endmodule : pgm_top
